//--- core/dac_host_ctrl.sv
// Host controller that drives the double-buffered DAC interface pins
//
// What this block does
// - Parallel write pulls chip select and write low together to load a word.
// - In serial mode write is frame sync; data follows its fall.
// - Load strobe is held high from reset and power-up.
// - Serial clock high and low phases stay within 40 to 60 percent.
// - Each serial frame is 16 clocked bits holding the 14-bit word.
`timescale 1ns/10ps
module dac_host_ctrl
    import dac_host_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Mode strap: high asks the board to tie chip select to the high rail
    output logic serial_mode_sel,
    // Parallel strobes and frame sync
    output logic chip_select_n,
    output logic write_sync_n,
    // Shared data pins
    output logic msb_or_serial_in,
    output logic bit12_or_serial_clock,
    output logic bit11_or_bit_order,
    output logic bit10_or_alignment,
    output logic [9:0] parallel_word_bits,
    // Output latch load strobe
    output logic output_latch_load_n
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        state_t state;
        logic [3:0] ctrl;
        logic [WORD_W-1:0] word;
        logic done;
        logic refused;
        logic [FRAME_BITS-1:0] frame;
        logic [3:0] bitcnt;
        logic [15:0] rdata;
        logic mode_sel;
        logic cs_n;
        logic wr_n;
        logic d13;
        logic d12;
        logic d11;
        logic d10;
        logic [9:0] dlow;
        logic output_latch_load_n_n;
    } ctrl_state_t;

    ctrl_state_t st_reg;
    ctrl_state_t st_next;

    logic tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic tmr_expired;
    logic [FRAME_BITS-1:0] new_frame;

    logic idle;
    logic wr_ctrl;
    logic wr_data;
    logic wr_load;
    logic wr_status;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    serial_frame_builder u_frame (
        .word(wdata[WORD_W-1:0]),
        .msb_first(st_reg.ctrl[CTRL_MSB_FIRST]),
        .justify_end(st_reg.ctrl[CTRL_JUSTIFY_END]),
        .frame(new_frame)
    );

    pulse_timer u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .load(tmr_load),
        .load_val(tmr_val),
        .expired(tmr_expired)
    );

    always_comb
    begin
        idle = (st_reg.state == S_IDLE);
        wr_ctrl = 1'b0;
        wr_data = 1'b0;
        wr_load = 1'b0;
        wr_status = 1'b0;
        if (wr && addr == OFS_CTRL)
        begin
            wr_ctrl = 1'b1;
        end
        else if (wr && addr == OFS_DATA)
        begin
            wr_data = 1'b1;
        end
        else if (wr && addr == OFS_LOAD)
        begin
            wr_load = 1'b1;
        end
        else if (wr && addr == OFS_STATUS)
        begin
            wr_status = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        st_next = st_reg;
        tmr_load = 1'b0;
        tmr_val = '0;
        st_next.rdata = '0;

        // Read data stands only in the cycle after the read strobe
        if (rd)
        begin
            if (addr == OFS_CTRL)
            begin
                st_next.rdata = {12'h000, st_reg.ctrl};
            end
            else if (addr == OFS_DATA)
            begin
                st_next.rdata = {2'b00, st_reg.word};
            end
            else if (addr == OFS_STATUS)
            begin
                st_next.rdata = {13'h0, st_reg.refused, st_reg.done,
                                 !idle};
            end
        end

        // Write-one clears; a set later in this process wins
        if (wr_status)
        begin
            if (wdata[ST_DONE])
            begin
                st_next.done = 1'b0;
            end
            if (wdata[ST_REFUSED])
            begin
                st_next.refused = 1'b0;
            end
        end

        // Requests during a transfer are dropped, never queued
        if (!idle && (wr_ctrl || wr_data || wr_load))
        begin
            st_next.refused = 1'b1;
        end

        case (st_reg.state)
            S_IDLE:
            begin
                if (wr_ctrl)
                begin
                    st_next.ctrl = wdata[3:0];
                    st_next.mode_sel = wdata[CTRL_SERIAL];
                    if (wdata[CTRL_SERIAL])
                    begin
                        // Shared pins take their serial roles
                        st_next.d12 = 1'b1;
                        st_next.d11 = wdata[CTRL_MSB_FIRST];
                        // Alignment pin low puts the valid bits at the end
                        st_next.d10 = !wdata[CTRL_JUSTIFY_END];
                        st_next.dlow = '0;
                    end
                end
                else if (wr_data)
                begin
                    st_next.word = wdata[WORD_W-1:0];
                    tmr_load = 1'b1;
                    if (st_reg.ctrl[CTRL_SERIAL])
                    begin
                        // Sync falls with the first bit on the pin
                        st_next.frame = new_frame;
                        st_next.bitcnt = '0;
                        st_next.wr_n = 1'b0;
                        st_next.d13 = new_frame[0];
                        tmr_val = SYNC_LD;
                        st_next.state = S_SSYNC;
                    end
                    else
                    begin
                        // Bit 0 of the word on pin 0 upward
                        st_next.dlow = wdata[9:0];
                        st_next.d10 = wdata[10];
                        st_next.d11 = wdata[11];
                        st_next.d12 = wdata[12];
                        st_next.d13 = wdata[13];
                        tmr_val = DSU_LD;
                        st_next.state = S_PSETUP;
                    end
                end
                else if (wr_load)
                begin
                    st_next.output_latch_load_n_n = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = LOAD_LD;
                    st_next.state = S_LOAD;
                end
            end
            S_PSETUP:
            begin
                if (tmr_expired)
                begin
                    // Both low: latch follows the pins
                    st_next.cs_n = 1'b0;
                    st_next.wr_n = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = WR_LD;
                    st_next.state = S_PSTROBE;
                end
            end
            S_PSTROBE:
            begin
                if (tmr_expired)
                begin
                    // Rising strobes capture; data still held
                    st_next.cs_n = 1'b1;
                    st_next.wr_n = 1'b1;
                    tmr_load = 1'b1;
                    tmr_val = DH_LD;
                    st_next.state = S_PHOLD;
                end
            end
            S_PHOLD:
            begin
                if (tmr_expired)
                begin
                    st_next.done = 1'b1;
                    if (st_reg.ctrl[CTRL_AUTO_LOAD])
                    begin
                        st_next.output_latch_load_n_n = 1'b0;
                        tmr_load = 1'b1;
                        tmr_val = LOAD_LD;
                        st_next.state = S_LOAD;
                    end
                    else
                    begin
                        st_next.state = S_IDLE;
                    end
                end
            end
            S_SSYNC, S_SHIGH:
            begin
                if (tmr_expired)
                begin
                    // Falling clock: device samples the bit
                    st_next.d12 = 1'b0;
                    tmr_load = 1'b1;
                    tmr_val = HALF_LD;
                    st_next.state = S_SLOW;
                end
            end
            S_SLOW:
            begin
                if (tmr_expired)
                begin
                    st_next.d12 = 1'b1;
                    st_next.bitcnt = st_reg.bitcnt + 1'b1;
                    if (st_reg.bitcnt == LAST_BIT)
                    begin
                        // Sync rises a half period after the last fall; the
                        // hold state keeps the load strobe off that edge
                        st_next.wr_n = 1'b1;
                        tmr_load = 1'b1;
                        tmr_val = DH_LD;
                        st_next.state = S_PHOLD;
                    end
                    else
                    begin
                        // Data changes on the rise, far from the fall
                        st_next.frame = st_reg.frame >> 1;
                        st_next.d13 = st_reg.frame[1];
                        tmr_load = 1'b1;
                        tmr_val = HALF_LD;
                        st_next.state = S_SHIGH;
                    end
                end
            end
            S_LOAD:
            begin
                if (tmr_expired)
                begin
                    st_next.output_latch_load_n_n = 1'b1;
                    st_next.done = 1'b1;
                    st_next.state = S_IDLE;
                end
            end
            default:
            begin
                st_next.state = S_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.state <= S_IDLE;
            st_reg.ctrl <= CTRL_RESET;
            st_reg.cs_n <= 1'b1;
            st_reg.wr_n <= 1'b1;
            st_reg.output_latch_load_n_n <= 1'b1;
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign serial_mode_sel = st_reg.mode_sel;
    assign chip_select_n = st_reg.cs_n;
    assign write_sync_n = st_reg.wr_n;
    assign msb_or_serial_in = st_reg.d13;
    assign bit12_or_serial_clock = st_reg.d12;
    assign bit11_or_bit_order = st_reg.d11;
    assign bit10_or_alignment = st_reg.d10;
    assign parallel_word_bits = st_reg.dlow;
    assign output_latch_load_n = st_reg.output_latch_load_n_n;

endmodule

//--- core/dac_host_pkg.sv
// Constants, register map and state codes for the DAC host controller
package dac_host_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and word geometry
    localparam int CLK_PERIOD_NS = 50;
    localparam int WORD_W = 14;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Pin timing, least times in ns
    localparam int T_WR_NS = 45;
    localparam int T_DSU_NS = 21;
    localparam int T_DH_NS = 10;
    localparam int T_LOAD_NS = 40;
    localparam int T_SYNC_SCLK_NS = 50;
    localparam int T_SCLK_NS = 150;
    localparam int T_SCLK_DH_NS = 75;

    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WR_CYC = min_cycles(T_WR_NS);
    localparam int DSU_CYC = min_cycles(T_DSU_NS);
    localparam int DH_CYC = min_cycles(T_DH_NS);
    localparam int LOAD_CYC = min_cycles(T_LOAD_NS);
    localparam int SYNC_CYC = min_cycles(T_SYNC_SCLK_NS);
    // Half period must cover half the cycle time and the data hold time
    localparam int HALF_CYC = min_cycles(
        (T_SCLK_DH_NS > T_SCLK_NS / 2) ? T_SCLK_DH_NS : T_SCLK_NS / 2);

    // Timer preloads: a load of N-1 gives N cycles in the state
    localparam logic [CNT_W-1:0] WR_LD = CNT_W'(WR_CYC - 1);
    localparam logic [CNT_W-1:0] DSU_LD = CNT_W'(DSU_CYC - 1);
    localparam logic [CNT_W-1:0] DH_LD = CNT_W'(DH_CYC - 1);
    localparam logic [CNT_W-1:0] LOAD_LD = CNT_W'(LOAD_CYC - 1);
    localparam logic [CNT_W-1:0] SYNC_LD = CNT_W'(SYNC_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_LD = CNT_W'(HALF_CYC - 1);
    localparam logic [3:0] LAST_BIT = 4'(FRAME_BITS - 1);

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets) and fields
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_DATA = 4'h4;
    localparam logic [3:0] OFS_LOAD = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    localparam int CTRL_SERIAL = 0;
    localparam int CTRL_MSB_FIRST = 1;
    localparam int CTRL_JUSTIFY_END = 2;
    localparam int CTRL_AUTO_LOAD = 3;
    localparam logic [3:0] CTRL_RESET = 4'h2;

    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer states
    typedef enum logic [7:0] {
        S_IDLE    = 8'b0000_0001,
        S_PSETUP  = 8'b0000_0010,
        S_PSTROBE = 8'b0000_0100,
        S_PHOLD   = 8'b0000_1000,
        S_SSYNC   = 8'b0001_0000,
        S_SLOW    = 8'b0010_0000,
        S_SHIGH   = 8'b0100_0000,
        S_LOAD    = 8'b1000_0000
    } state_t;

endpackage

//--- core/serial_frame_builder.sv
// Places the 14-bit word into a 16-bit serial frame, element 0 sent first
`timescale 1ns/10ps
module serial_frame_builder
    import dac_host_pkg::*;
(
    // Word and format
    input wire logic [WORD_W-1:0] word,
    input wire logic msb_first,
    input wire logic justify_end,
    // Frame in send order
    output logic [FRAME_BITS-1:0] frame
);

    for (genvar i = 0; i < FRAME_BITS; i++)
    begin : g_bit
        localparam int KS = i;
        localparam int KE = i - (FRAME_BITS - WORD_W);
        localparam bit KS_OK = (KS < WORD_W);
        localparam bit KE_OK = (KE >= 0);
        localparam int S = KS_OK ? KS : 0;
        localparam int E = KE_OK ? KE : 0;
        logic bit_s;
        logic bit_e;
        // Bit order decides which end of the word goes first
        assign bit_s = msb_first ? word[WORD_W-1-S] : word[S];
        assign bit_e = msb_first ? word[WORD_W-1-E] : word[E];
        // Unused frame slots are sent as zero
        assign frame[i] = justify_end ? (KE_OK ? bit_e : 1'b0)
                                      : (KS_OK ? bit_s : 1'b0);
    end

endmodule

//--- core/pulse_timer.sv
// Loadable down counter that times pin phases in core clock cycles
`timescale 1ns/10ps
module pulse_timer
    import dac_host_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    // Status
    output logic expired
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } tmr_state_t;

    tmr_state_t st_reg;
    tmr_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        if (load)
        begin
            st_next.cnt = load_val;
        end
        else if (st_reg.cnt != '0)
        begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    // Depends on the count alone: the sequencer's load follows this flag,
    // so gating it with load would close a combinational loop
    assign expired = (st_reg.cnt == '0);

endmodule

//--- test/dac_host_ctrl_chk.sv
// Pin-level checks on the DAC host controller
`timescale 1ns/10ps
module dac_host_ctrl_chk
    import dac_host_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Device pins
    input wire logic serial_mode_sel,
    input wire logic chip_select_n,
    input wire logic write_sync_n,
    input wire logic msb_or_serial_in,
    input wire logic bit12_or_serial_clock,
    input wire logic bit11_or_bit_order,
    input wire logic bit10_or_alignment,
    input wire logic [9:0] parallel_word_bits,
    input wire logic output_latch_load_n
);
    wire sck = bit12_or_serial_clock;
    wire [13:0] pins = {msb_or_serial_in, sck, bit11_or_bit_order,
        bit10_or_alignment, parallel_word_bits};
    logic [4:0] falls_reg;
    logic sck_reg;

    // Counts serial clock falls while sync is low
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            falls_reg <= 5'h00;
            sck_reg <= 1'b1;
        end
        else
        begin
            sck_reg <= sck;
            if (write_sync_n)
                falls_reg <= 5'h00;
            else if (sck_reg && !sck)
                falls_reg <= falls_reg + 5'h01;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_low_phase;
        !sck [*2] ##1 sck;
    endsequence
    sequence s_pins_held;
        $stable(pins) ##1 $stable(pins);
    endsequence

    a_load_after_reset:
        assert property ($rose(rst_n) |-> output_latch_load_n [*2])
        else $error("Load strobe low after reset");
    a_load_one_cycle:
        assert property ($fell(output_latch_load_n) |=> output_latch_load_n)
        else $error("Load strobe pulse too long");
    a_cs_off_serial:
        assert property (serial_mode_sel |-> chip_select_n)
        else $error("Chip select low in serial mode");
    a_cs_with_write:
        assert property (!chip_select_n |->
            !write_sync_n ##1 (chip_select_n && write_sync_n))
        else $error("Parallel strobes not paired");
    a_data_hold:
        assert property ($rose(chip_select_n) |-> s_pins_held)
        else $error("Data moved around strobe rise");
    a_clock_in_frame:
        assert property (serial_mode_sel && $fell(sck) |-> !write_sync_n)
        else $error("Serial clock fell outside frame");
    a_clock_low_phase:
        assert property (serial_mode_sel && $fell(sck) |-> s_low_phase)
        else $error("Serial clock low phase wrong");
    a_frame_sixteen:
        assert property (serial_mode_sel && $rose(write_sync_n) |->
            falls_reg == 5'h10)
        else $error("Frame not sixteen clocks");
endmodule

bind dac_host_ctrl dac_host_ctrl_chk chk (.core_clk, .rst_n,
    .serial_mode_sel, .chip_select_n, .write_sync_n, .msb_or_serial_in,
    .bit12_or_serial_clock, .bit11_or_bit_order, .bit10_or_alignment,
    .parallel_word_bits, .output_latch_load_n);

//--- test/dac_input_model.sv
// Behavioural model of the DAC's double-buffered input logic
`timescale 1ns/10ps
module dac_input_model
(
    // Mode strap and strobes
    input wire logic serial_strap,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic load_n,
    // Data pins, bit 13 first
    input wire logic [13:0] pins,
    // Latches
    output logic [13:0] in_word,
    output logic [13:0] out_word
);
    logic [15:0] shift;
    logic [4:0] bits;
    logic [13:0] valid;
    int i;

    // Transparent while both strobes low, holds from the first rise
    always @*
        if (!serial_strap && !cs_n && !wr_n)
            in_word = pins;

    always @(negedge wr_n)
        bits = 5'h00;

    // Bits count only while sync is low; parallel-only pins unused
    always @(negedge pins[12])
        if (serial_strap && !wr_n)
        begin
            shift = {shift[14:0], pins[13]};
            bits = bits + 5'h01;
        end

    // A short frame, e.g. cut by reset, leaves the latch alone
    always @(posedge wr_n)
        if (serial_strap && bits == 5'h10)
        begin
            valid = pins[10] ? shift[15:2] : shift[13:0];
            for (i = 0; i < 14; i++)
                in_word[i] = pins[11] ? valid[i] : valid[13 - i];
        end

    always @(negedge load_n)
        out_word = in_word;
endmodule

//--- test/dac_host_ctrl_tb.sv
// Self-checking bench for the DAC host controller
`timescale 1ns/10ps
module dac_host_ctrl_tb;
    import dac_host_pkg::*;

    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic serial_mode_sel, chip_select_n, write_sync_n;
    logic msb_or_serial_in, bit12_or_serial_clock;
    logic bit11_or_bit_order, bit10_or_alignment, output_latch_load_n;
    logic [9:0] parallel_word_bits;
    logic [13:0] in_word, out_word;
    logic [13:0] exp_q[$];
    logic [31:0] seed = 32'h0000_3911;
    int bad_count = 0;
    int samples_checked = 0;

    always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    dac_host_ctrl dut (.core_clk, .rst_n, .ce, .addr, .wdata, .wr, .rd,
        .rdata, .serial_mode_sel, .chip_select_n, .write_sync_n,
        .msb_or_serial_in, .bit12_or_serial_clock, .bit11_or_bit_order,
        .bit10_or_alignment, .parallel_word_bits, .output_latch_load_n);

    dac_input_model dev (.serial_strap(serial_mode_sel),
        .cs_n(chip_select_n), .wr_n(write_sync_n),
        .load_n(output_latch_load_n), .pins({msb_or_serial_in,
        bit12_or_serial_clock, bit11_or_bit_order, bit10_or_alignment,
        parallel_word_bits}), .in_word, .out_word);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string what, input logic [15:0] e,
        input logic [15:0] s);
        samples_checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_idle();
        logic [15:0] s;
        int n;
        for (n = 0; n < 100; n++)
        begin
            reg_read(OFS_STATUS, s);
            if (s[ST_BUSY] === 1'b0)
                break;
        end
        if (n == 100)
            check("busy", 16'h0000, s);
    endtask

    // The expectation is queued before the word can reach the pins
    task automatic send(input logic [13:0] w, input bit load);
        if (load)
            exp_q.push_back(w);
        reg_write(OFS_DATA, {2'b00, w});
        wait_idle();
        reg_write(OFS_STATUS, 16'h0006);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(negedge output_latch_load_n)
    begin
        #1;
        if (exp_q.size() == 0)
            check("spare load strobe", 16'h0000, 16'h0001);
        else
            check("output latch", exp_q.pop_front(), out_word);
    end

    initial
    begin
        #(CLK_PERIOD_NS * 20000);
        check("watchdog", 16'h0000, 16'h0001);
        test_done();
    end

    initial
    begin
        logic [15:0] v;
        int m, k;
        repeat (4) @(posedge core_clk);
        check("load in reset", 16'h0001, output_latch_load_n);
        rst_n <= 1'b1;
        reg_read(OFS_CTRL, v);
        check("ctrl reset", {12'h000, CTRL_RESET}, v);
        reg_read(4'h2, v);
        check("unmapped read", 16'h0000, v);
        reg_write(OFS_CTRL, 16'h0008);
        for (k = 0; k < 6; k++)
        begin
            seed = xorshift(seed);
            v = (k == 0) ? 16'h2000 : (k == 1) ? 16'h1fff : seed[15:0];
            send(v[13:0], 1'b1);
        end
        // Second word lands while busy and must be dropped
        seed = xorshift(seed);
        exp_q.push_back(seed[13:0]);
        reg_write(OFS_DATA, {2'b00, seed[13:0]});
        reg_write(OFS_DATA, ~{2'b00, seed[13:0]});
        wait_idle();
        reg_read(OFS_STATUS, v);
        check("refused status", 16'h0006, v);
        reg_write(OFS_STATUS, 16'h0006);
        // Serial: order in bit 1, alignment in bit 2
        for (m = 0; m < 4; m++)
        begin
            reg_write(OFS_CTRL, 16'(9 + 2 * m));
            for (k = 0; k < 3; k++)
            begin
                seed = xorshift(seed);
                send(seed[13:0], 1'b1);
            end
        end
        reg_write(OFS_DATA, 16'h1234);
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("load in reset", 16'h0001, output_latch_load_n);
        rst_n <= 1'b1;
        reg_write(OFS_CTRL, 16'h0000);
        seed = xorshift(seed);
        send(seed[13:0], 1'b0);
        check("input latch", seed[13:0], in_word);
        exp_q.push_back(seed[13:0]);
        reg_write(OFS_LOAD, 16'h0000);
        wait_idle();
        // A low enable must hold the transfer before its strobe
        reg_write(OFS_DATA, {2'b00, ~seed[13:0]});
        ce <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("frozen latch", {2'b00, seed[13:0]}, in_word);
        ce <= 1'b1;
        wait_idle();
        check("input latch", {2'b00, ~seed[13:0]}, in_word);
        check("queue left", 16'h0000, 16'(exp_q.size()));
        test_done();
    end
endmodule
